// ### dv/usb_device_control_core_tb_top.sv
// Purpose: self-checking bench of usbdc_core
// Assumes: short timers; line idles only in the suspend case
// Notes: registers over classic Wishbone
`timescale 1ns/1ps
module usb_device_control_core_tb_top;
   logic CLK = 0, SYS_RST = 1, cyc = 0, stb = 0, we = 0, go = 0, vbus = 0, brst = 0, ack;
   logic idle = 0, eor = 0, srp = 0, vdrop = 0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = '0, rdat, wq;
   logic [6:0] ta = 7'h00;
   logic [2:0] te = 3'h0, r;
   logic pu_dp, pu_dm;
   int n_fail = 0, n_compared = 0, seed = 32'h0000_85c2, e, c;
   usbdc_pkg::usbdc_tok_t tok;
   usbdc_pkg::usbdc_resp_t rsp;
   always #2 CLK = ~CLK;
   usbdc_host_model host (.clk(CLK), .go(go), .addr(ta), .ep(te), .tok(tok));
   usbdc_core #(.SUSP_CYC(20), .RWK_CYC(30), .RSM_CYC(10), .BCON_CYC(40)) uut (
      .CLK(CLK), .SYS_RST(SYS_RST), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .TOKEN(tok), .LINE_IDLE(idle), .BUS_RESET(brst), .END_OF_RESUME(eor),
      .SRP_SEEN(srp), .RESPONSE(rsp), .VBUS_PIN(vbus), .VBUS_DROP_PIN(vdrop),
      .PERIPH_CONN_PIN(1'b0), .PULLUP_DP(pu_dp), .PULLUP_DM(pu_dm), .RESUME_DRIVE(),
      .FULL_SPEED(), .VBUS_ON(), .MACRO_CLK_EN(), .DEV_IRQ(), .EP_IRQ());
   task automatic tally_and_finish();
      if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic ck(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge CLK);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      dat <= d;
      i = 0;
      do begin
         @(posedge CLK);
         i++;
      end while (ack !== 1'b1 && i < 20);
      wq = rdat;
      cyc <= 0;
      stb <= 0;
      if (i >= 20) begin
         n_fail++;
         tally_and_finish();
      end
   endtask
   // token out, response sampled one cycle after the core takes it
   task automatic tk(input logic [6:0] a, input logic [2:0] e);
      @(posedge CLK);
      go <= 1;
      ta <= a;
      te <= e;
      @(posedge CLK);
      go <= 0;
      repeat (2) @(posedge CLK);
      r = {rsp.valid, rsp.code};
   endtask
   function automatic logic [31:0] cfg_exp(input int ep, input int code);
      return (code <= (ep == 1 ? 5 : 3)) ? 32'h0000_8000 : '0;
   endfunction
   initial begin
      repeat (12) @(posedge CLK);
      SYS_RST <= 0;
      wb(0, 8'h00, '0);
      ck(wq, 32'h0000_0006);
      wb(0, 8'h20, '0);
      ck(wq, '0);
      vbus <= 1;
      wb(1, 8'h00, 32'h0000_0001);
      repeat (4) @(posedge CLK);
      ck(32'({pu_dm, pu_dp}), 32'h0000_0001);
      wb(1, 8'h10, 32'h0000_0001);
      wb(1, 8'h18, 32'h0000_0053);
      wb(0, 8'h18, '0);
      ck(wq & 32'h0000_8000, cfg_exp(1, 5));
      tk(7'h00, 3'h1);
      ck(32'(r), 32'h0000_0005);
      // drop the out-received mark so the stalled token is seen alone
      wb(1, 8'h1C, 32'h0000_0002);
      wb(1, 8'h18, 32'h0000_0453);
      tk(7'h00, 3'h1);
      ck(32'(r), 32'h0000_0007);
      wb(0, 8'h1C, '0);
      ck(wq & 32'h0000_0007, 32'h0000_0001);
      wb(1, 8'h18, 32'h0000_0253);
      wb(0, 8'h18, '0);
      ck(wq & 32'h0001_C200, 32'h0001_8000);
      wb(1, 8'h14, 32'h0000_0002);
      wb(0, 8'h1C, '0);
      ck(wq, '0);
      wb(0, 8'h18, '0);
      ck(wq & 32'h0001_0001, 32'h0001_0001);
      wb(1, 8'h0C, 32'h0000_0005);
      tk(7'h05, 3'h1);
      ck(32'(r), '0);
      wb(1, 8'h0C, 32'h0000_0085);
      tk(7'h05, 3'h1);
      ck(32'(r), 32'h0000_0005);
      brst <= 1;
      @(posedge CLK);
      brst <= 0;
      wb(0, 8'h0C, '0);
      ck(wq, '0);
      wb(0, 8'h18, '0);
      ck(wq & 32'h0001_0001, '0);
      repeat (4) begin
         e = 2 + ($random(seed) & 3);
         c = $random(seed) & 7;
         wb(1, 8'h10, 32'(e));
         wb(1, 8'h18, 32'(c * 16 + 3));
         wb(0, 8'h18, '0);
         ck(wq & 32'h0000_8000, cfg_exp(e, c));
      end
      wb(1, 8'h00, 32'h0000_0061);
      srp <= 1;
      vdrop <= 1;
      @(posedge CLK);
      srp <= 0;
      repeat (50) @(posedge CLK);
      wb(0, 8'h04, '0);
      ck(wq & 32'h0000_00E0, 32'h0000_00E0);
      wb(1, 8'h04, 32'h0000_00E0);
      wb(0, 8'h04, '0);
      ck(wq & 32'h0000_00E0, '0);
      // suspend, then remote wake and resume; read before a second suspend
      wb(1, 8'h00, 32'h0000_0011);
      idle <= 1;
      repeat (70) @(posedge CLK);
      wb(0, 8'h04, '0);
      ck(wq & 32'h0000_000F, 32'h0000_0004);
      wb(0, 8'h00, '0);
      ck(wq & 32'h0000_0010, '0);
      eor <= 1;
      idle <= 0;
      @(posedge CLK);
      eor <= 0;
      wb(0, 8'h04, '0);
      ck(wq & 32'h0000_000F, 32'h0000_000E);
      wb(1, 8'h10, 32'h0000_0001);
      wb(1, 8'h18, 32'h0000_0053);
      wb(1, 8'h00, '0);
      tk(7'h00, 3'h1);
      ck(32'(r), '0);
      tally_and_finish();
   end
endmodule

// ### dv/usbdc_core_sva.sv
// Purpose: port checks of usbdc_core
// Assumes: one clock, async high reset
// Notes: bound to every core instance
`timescale 1ns/1ps
module usbdc_core_sva (
   // clock, reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // bus, events
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_ACK_O,
   input wire usbdc_pkg::usbdc_tok_t TOKEN,
   input wire usbdc_pkg::usbdc_resp_t RESPONSE,
   // pins
   input wire logic VBUS_PIN,
   input wire logic PULLUP_DP,
   input wire logic PULLUP_DM,
   input wire logic MACRO_CLK_EN
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("ack late");
   a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
   a_resp_cause:
      assert property (RESPONSE.valid |-> $past(TOKEN.valid)) else $error("stray response");
   a_frozen_silent:
      assert property (RESPONSE.valid |-> MACRO_CLK_EN) else $error("answered");
   a_pullup_one: assert property (!(PULLUP_DP && PULLUP_DM)) else $error("two pullups");
   a_pullup_vbus:
      assert property (PULLUP_DP || PULLUP_DM |-> $past(VBUS_PIN, 3)) else $error("no vbus");
   a_reset_quiet:
      assert property ($fell(SYS_RST) |-> !PULLUP_DP && !PULLUP_DM && !MACRO_CLK_EN)
      else $error("not idle");
   a_resp_code:
      assert property (RESPONSE.valid |-> RESPONSE.code inside {usbdc_pkg::HS_ACK,
         usbdc_pkg::HS_STALL}) else $error("bad code");
endmodule
bind usbdc_core usbdc_core_sva u_sva (.CLK(CLK), .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .TOKEN(TOKEN), .RESPONSE(RESPONSE),
   .VBUS_PIN(VBUS_PIN), .PULLUP_DP(PULLUP_DP), .PULLUP_DM(PULLUP_DM),
   .MACRO_CLK_EN(MACRO_CLK_EN));

// ### dv/usbdc_host_model.sv
// Purpose: host-side token source
// Assumes: one OUT token per go pulse
// Notes: idle fields invert each cycle, so a stale value comes back every second cycle
`timescale 1ns/1ps
module usbdc_host_model (
   // clock
   input wire logic clk,
   // request
   input wire logic go,
   input wire logic [6:0] addr,
   input wire logic [2:0] ep,
   // bus side
   output usbdc_pkg::usbdc_tok_t tok
);
   always_ff @(posedge clk) begin
      tok.valid <= go;
      tok.kind <= usbdc_pkg::TK_OUT;
      tok.addr <= go ? addr : ~tok.addr;
      tok.ep <= go ? ep : ~tok.ep;
   end
endmodule

// ### src/usbdc_core.sv
// Purpose: usb device control core: reset, endpoints, address, suspend, stall
// Assumes: token events come from a serial engine on CLK; pins are synchronised
// Notes: registers on classic Wishbone, answer one cycle after the strobe
`timescale 1ns/1ps
module usbdc_core #(
   parameter int SUSP_CYC = usbdc_pkg::SUSP_CYC,
   parameter int RWK_CYC = usbdc_pkg::RWK_CYC,
   parameter int RSM_CYC = usbdc_pkg::RSM_CYC,
   parameter int BCON_CYC = usbdc_pkg::BCON_CYC
) (
   // clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // serial engine events
   input wire usbdc_pkg::usbdc_tok_t TOKEN,
   input wire logic LINE_IDLE,
   input wire logic BUS_RESET,
   input wire logic END_OF_RESUME,
   input wire logic SRP_SEEN,
   output usbdc_pkg::usbdc_resp_t RESPONSE,
   // pins
   input wire logic VBUS_PIN,
   input wire logic VBUS_DROP_PIN,
   input wire logic PERIPH_CONN_PIN,
   output logic PULLUP_DP,
   output logic PULLUP_DM,
   output logic RESUME_DRIVE,
   output logic FULL_SPEED,
   output logic VBUS_ON,
   output logic MACRO_CLK_EN,
   // interrupt lines
   output logic DEV_IRQ,
   output logic EP_IRQ
);
   localparam int N = usbdc_pkg::NEP;

   function automatic logic [8:0] ep_max(input logic [2:0] ep);
      if (ep == 3'd0) ep_max = usbdc_pkg::EP0_MAX;
      else if (ep == 3'd1) ep_max = usbdc_pkg::EP1_MAX;
      else ep_max = usbdc_pkg::EPN_MAX;
   endfunction

   // per-bank bytes are 8 shl size code; must fit this endpoint's buffer
   function automatic logic size_fits(input logic [2:0] ep, input logic [2:0] code);
      logic [11:0] bytes;
      bytes = 12'h008 << code;
      size_fits = (code <= 3'd5) && (bytes <= {3'b000, ep_max(ep)});
   endfunction

   logic [6:0] ctrl_r;
   logic [usbdc_pkg::NFLAGS-1:0] flag_r, inten_r;
   logic [6:0] addr_r;
   logic addr_en_r;
   logic [2:0] sel_r;
   logic [N-1:0] ep_en_r, ep_memory_allocate_bit_r, ep_bk_r, ep_stall_r, ep_tog_r;
   logic [N-1:0] ep_stalled_r, ep_rxout_r, ep_bank_access_allowed_r, ep_stie_r, ep_rxie_r;
   logic [2:0] ep_size_r [N];
   logic [N-1:0] ep_rst_r;
   logic ack_r;
   logic [31:0] rdat_r;
   usbdc_pkg::usbdc_resp_t resp_r;
   usbdc_pkg::usbdc_lstate_t lstate_r;
   logic fs_r, pu_dp_r, pu_dm_r, full_r, rsm_r, devirq_r, epirq_r, clken_r, idle_q_r, vdrop_q_r;
   logic vbus_s, vdrop_s, pconn_s;

   logic soft_rst, wr, frozen, line_act_rise, vdrop_rise, attach;
   logic t_susp, t_rwk, t_rsm, t_bcon;
   logic [N-1:0] sel_hot, ep_hold, cfg_ok, tok_hot;
   logic [31:0] wdat;

   assign soft_rst = !ctrl_r[usbdc_pkg::CT_MACRO_EN];
   assign frozen = ctrl_r[usbdc_pkg::CT_FREEZE] || soft_rst;
   assign attach = !ctrl_r[usbdc_pkg::CT_DETACH] && vbus_s;
   assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && ack_r;
   assign wdat = WB_DAT_I & {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}},
                             {8{WB_SEL_I[0]}}};
   assign sel_hot = (sel_r < 3'd7) ? 7'(1 << sel_r) : '0;
   assign line_act_rise = idle_q_r && !LINE_IDLE;
   assign vdrop_rise = vdrop_s && !vdrop_q_r;
   assign tok_hot = (TOKEN.valid && TOKEN.ep < 3'd7) ? 7'(1 << TOKEN.ep) : '0;

   always_comb begin
      for (int i = 0; i < N; i++) begin
         ep_hold[i] = !ep_en_r[i] || ep_rst_r[i];
         cfg_ok[i] = ep_en_r[i] && ep_memory_allocate_bit_r[i] && size_fits(3'(i), ep_size_r[i]);
      end
   end

   usbdc_sync #(.W(3)) u_sync (
      .clk(CLK),
      .rst(SYS_RST),
      .din({VBUS_PIN, VBUS_DROP_PIN, PERIPH_CONN_PIN}),
      .dout({vbus_s, vdrop_s, pconn_s})
   );

   // suspend, wake and resume timers stop while the macro clock is frozen; u_bcon ignores freeze but stops on macro disable
   usbdc_timer u_susp (
      .clk(CLK),
      .rst(SYS_RST),
      .run(!frozen && LINE_IDLE && lstate_r == usbdc_pkg::LN_ACTIVE),
      .limit(usbdc_pkg::TMR_W'(SUSP_CYC)),
      .done(t_susp)
   );
   usbdc_timer u_rwk (
      .clk(CLK),
      .rst(SYS_RST),
      .run(!frozen && LINE_IDLE && lstate_r == usbdc_pkg::LN_SUSPEND
           && ctrl_r[usbdc_pkg::CT_RWAKE] && flag_r[usbdc_pkg::FL_SUSP]),
      .limit(usbdc_pkg::TMR_W'(RWK_CYC)),
      .done(t_rwk)
   );
   usbdc_timer u_rsm (
      .clk(CLK),
      .rst(SYS_RST),
      .run(!frozen && lstate_r == usbdc_pkg::LN_RESUME),
      .limit(usbdc_pkg::TMR_W'(RSM_CYC)),
      .done(t_rsm)
   );
   usbdc_timer u_bcon (
      .clk(CLK),
      .rst(SYS_RST),
      .run(!soft_rst && ctrl_r[usbdc_pkg::CT_HOST] && ctrl_r[usbdc_pkg::CT_VBUS_REQ]
           && !pconn_s),
      .limit(usbdc_pkg::TMR_W'(BCON_CYC)),
      .done(t_bcon)
   );

   // bus slave handshake and read mux
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ack_r <= 1'b0;
         rdat_r <= '0;
      end else begin
         ack_r <= WB_CYC_I && WB_STB_I && !ack_r;
         rdat_r <= '0;
         if (WB_CYC_I && WB_STB_I && !ack_r && !WB_WE_I) begin
            if (WB_ADR_I == usbdc_pkg::OFS_CTRL) rdat_r <= {25'h0, ctrl_r};
            else if (WB_ADR_I == usbdc_pkg::OFS_FLAGS) rdat_r <= {24'h0, flag_r};
            else if (WB_ADR_I == usbdc_pkg::OFS_INTEN) rdat_r <= {24'h0, inten_r};
            else if (WB_ADR_I == usbdc_pkg::OFS_ADDR) rdat_r <= {24'h0, addr_en_r, addr_r};
            else if (WB_ADR_I == usbdc_pkg::OFS_EPSEL) rdat_r <= {29'h0, sel_r};
            else if (WB_ADR_I == usbdc_pkg::OFS_EPCFG && sel_r < 3'd7) begin
               rdat_r[usbdc_pkg::EC_EN] <= ep_en_r[sel_r];
               rdat_r[usbdc_pkg::EC_MEMORY_ALLOCATE_BIT] <= ep_memory_allocate_bit_r[sel_r];
               rdat_r[usbdc_pkg::EC_BANKS] <= ep_bk_r[sel_r];
               rdat_r[usbdc_pkg::EC_SIZE_LO +: 3] <= ep_size_r[sel_r];
               rdat_r[usbdc_pkg::EC_STALL_IE] <= ep_stie_r[sel_r];
               rdat_r[usbdc_pkg::EC_RX_IE] <= ep_rxie_r[sel_r];
               rdat_r[usbdc_pkg::EC_STALL_RQ] <= ep_stall_r[sel_r];
               rdat_r[usbdc_pkg::EC_CFG_OK] <= cfg_ok[sel_r];
               rdat_r[usbdc_pkg::EC_TOGGLE] <= ep_tog_r[sel_r];
            end else if (WB_ADR_I == usbdc_pkg::OFS_EPINT && sel_r < 3'd7) begin
               rdat_r[usbdc_pkg::EI_STALLED] <= ep_stalled_r[sel_r];
               rdat_r[usbdc_pkg::EI_RX_OUT] <= ep_rxout_r[sel_r];
               rdat_r[usbdc_pkg::EI_BANK_ACCESS_ALLOWED] <= ep_bank_access_allowed_r[sel_r];
            end
         end
      end
   end

   // control: only this register survives a macro disable
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ctrl_r <= usbdc_pkg::CTRL_RST;
      end else begin
         if (wr && WB_ADR_I == usbdc_pkg::OFS_CTRL && WB_SEL_I[0]) ctrl_r <= wdat[6:0];
         if (t_rsm) ctrl_r[usbdc_pkg::CT_RWAKE] <= 1'b0;
      end
   end

   // line state: active, suspended, driving resume
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         lstate_r <= usbdc_pkg::LN_ACTIVE;
         fs_r <= 1'b0;
      end else if (soft_rst || BUS_RESET) begin
         lstate_r <= usbdc_pkg::LN_ACTIVE;
         fs_r <= 1'b0;
      end else begin
         case (lstate_r)
            usbdc_pkg::LN_ACTIVE: begin
               if (t_susp) begin
                  lstate_r <= usbdc_pkg::LN_SUSPEND;
                  fs_r <= 1'b1;
               end
            end
            usbdc_pkg::LN_SUSPEND: begin
               if (t_rwk) lstate_r <= usbdc_pkg::LN_RESUME;
               else if (line_act_rise) lstate_r <= usbdc_pkg::LN_ACTIVE;
            end
            usbdc_pkg::LN_RESUME: begin
               if (t_rsm) lstate_r <= usbdc_pkg::LN_ACTIVE;
            end
            default: lstate_r <= usbdc_pkg::LN_ACTIVE;
         endcase
      end
   end

   // device flags: hardware set wins over software clear
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         flag_r <= '0;
         inten_r <= '0;
         idle_q_r <= 1'b1;
         vdrop_q_r <= 1'b0;
      end else if (soft_rst) begin
         flag_r <= '0;
         inten_r <= '0;
         idle_q_r <= 1'b1;
         vdrop_q_r <= vdrop_s;
      end else begin
         idle_q_r <= LINE_IDLE;
         vdrop_q_r <= vdrop_s;
         if (wr && WB_ADR_I == usbdc_pkg::OFS_INTEN && WB_SEL_I[0]) inten_r <= wdat[7:0];
         if (wr && WB_ADR_I == usbdc_pkg::OFS_FLAGS) flag_r <= flag_r & ~wdat[7:0];
         // wake detect still runs while frozen
         if (line_act_rise) begin
            flag_r[usbdc_pkg::FL_WAKE] <= 1'b1;
            flag_r[usbdc_pkg::FL_SUSP] <= 1'b0;
         end
         if (t_susp) begin
            flag_r[usbdc_pkg::FL_SUSP] <= 1'b1;
            flag_r[usbdc_pkg::FL_WAKE] <= 1'b0;
         end
         if (t_rwk) begin
            flag_r[usbdc_pkg::FL_RSM_SENT] <= 1'b1;
            flag_r[usbdc_pkg::FL_SUSP] <= 1'b0;
         end
         if (END_OF_RESUME) flag_r[usbdc_pkg::FL_EORSM] <= 1'b1;
         if (BUS_RESET) flag_r[usbdc_pkg::FL_BUS_RST] <= 1'b1;
         if (t_bcon) flag_r[usbdc_pkg::FL_BCON_ERR] <= 1'b1;
         if (vdrop_rise) flag_r[usbdc_pkg::FL_VBUS_ERR] <= 1'b1;
         if (SRP_SEEN && ctrl_r[usbdc_pkg::CT_HOST]) flag_r[usbdc_pkg::FL_SRP] <= 1'b1;
      end
   end

   // device address; firmware writes field and enable apart
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         addr_r <= usbdc_pkg::DEF_ADDR;
         addr_en_r <= 1'b0;
      end else if (soft_rst || BUS_RESET) begin
         addr_r <= usbdc_pkg::DEF_ADDR;
         addr_en_r <= 1'b0;
      end else if (wr && WB_ADR_I == usbdc_pkg::OFS_ADDR && WB_SEL_I[0]) begin
         addr_r <= wdat[6:0];
         addr_en_r <= wdat[usbdc_pkg::AD_ENABLE];
      end
   end

   // endpoint select and configuration
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         sel_r <= '0;
         ep_rst_r <= '0;
         ep_en_r <= '0;
         ep_memory_allocate_bit_r <= '0;
         ep_bk_r <= '0;
         ep_stie_r <= '0;
         ep_rxie_r <= '0;
         for (int i = 0; i < N; i++) ep_size_r[i] <= '0;
      end else if (soft_rst) begin
         sel_r <= '0;
         ep_rst_r <= '0;
         ep_en_r <= '0;
         ep_memory_allocate_bit_r <= '0;
         ep_bk_r <= '0;
         ep_stie_r <= '0;
         ep_rxie_r <= '0;
         for (int i = 0; i < N; i++) ep_size_r[i] <= '0;
      end else begin
         ep_rst_r <= '0;
         if (wr && WB_ADR_I == usbdc_pkg::OFS_EPSEL && WB_SEL_I[0]) sel_r <= wdat[2:0];
         if (wr && WB_ADR_I == usbdc_pkg::OFS_EPRST && WB_SEL_I[0]) ep_rst_r <= wdat[6:0];
         for (int i = 0; i < N; i++) begin
            if (wr && WB_ADR_I == usbdc_pkg::OFS_EPCFG && sel_hot[i]) begin
               if (WB_SEL_I[0]) begin
                  ep_en_r[i] <= wdat[usbdc_pkg::EC_EN];
                  ep_memory_allocate_bit_r[i] <= wdat[usbdc_pkg::EC_MEMORY_ALLOCATE_BIT];
                  ep_bk_r[i] <= wdat[usbdc_pkg::EC_BANKS];
                  ep_size_r[i] <= wdat[usbdc_pkg::EC_SIZE_LO +: 3];
               end
               if (WB_SEL_I[1]) begin
                  ep_stie_r[i] <= wdat[usbdc_pkg::EC_STALL_IE];
                  ep_rxie_r[i] <= wdat[usbdc_pkg::EC_RX_IE];
               end
            end
            if (BUS_RESET && i != 0) ep_en_r[i] <= 1'b0;
         end
      end
   end

   // data toggle: kept by endpoint reset, cleared by disable
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ep_tog_r <= '0;
      end else if (soft_rst) begin
         ep_tog_r <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (!ep_en_r[i]) ep_tog_r[i] <= 1'b0;
            else if (wr && WB_ADR_I == usbdc_pkg::OFS_EPCFG && sel_hot[i] && WB_SEL_I[1]
                     && wdat[usbdc_pkg::EC_TOG_RST]) ep_tog_r[i] <= 1'b0;
            else if (tok_hot[i] && resp_ack(i)) ep_tog_r[i] <= !ep_tog_r[i];
         end
      end
   end

   // toggle only moves when a handshake really goes out
   function automatic logic resp_ack(input int i);
      resp_ack = !frozen && !ep_hold[i] && cfg_ok[i] && !ep_stall_r[i] && addr_match();
   endfunction

   function automatic logic addr_match();
      addr_match = TOKEN.addr == (addr_en_r ? addr_r : usbdc_pkg::DEF_ADDR);
   endfunction

   // stall request: set bit, self-clearing clear bit
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ep_stall_r <= '0;
      end else if (soft_rst) begin
         ep_stall_r <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (wr && WB_ADR_I == usbdc_pkg::OFS_EPCFG && sel_hot[i] && WB_SEL_I[1]) begin
               if (wdat[usbdc_pkg::EC_STALL_CLR]) ep_stall_r[i] <= 1'b0;
               else if (wdat[usbdc_pkg::EC_STALL_SET]) ep_stall_r[i] <= 1'b1;
            end
         end
      end
   end

   // endpoint flags, cleared while the endpoint is held in reset
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ep_stalled_r <= '0;
         ep_rxout_r <= '0;
         ep_bank_access_allowed_r <= '0;
      end else if (soft_rst) begin
         ep_stalled_r <= '0;
         ep_rxout_r <= '0;
         ep_bank_access_allowed_r <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (ep_hold[i]) begin
               ep_stalled_r[i] <= 1'b0;
               ep_rxout_r[i] <= 1'b0;
               ep_bank_access_allowed_r[i] <= 1'b0;
            end else begin
               if (wr && WB_ADR_I == usbdc_pkg::OFS_EPINT && sel_hot[i] && WB_SEL_I[0]) begin
                  if (wdat[usbdc_pkg::EI_STALLED]) ep_stalled_r[i] <= 1'b0;
                  if (wdat[usbdc_pkg::EI_RX_OUT]) begin
                     ep_rxout_r[i] <= 1'b0;
                     ep_bank_access_allowed_r[i] <= 1'b0;
                  end
               end
               if (tok_hot[i] && addr_match() && cfg_ok[i] && !frozen) begin
                  if (ep_stall_r[i]) ep_stalled_r[i] <= 1'b1;
                  else if (TOKEN.kind == usbdc_pkg::TK_OUT) begin
                     ep_rxout_r[i] <= 1'b1;
                     ep_bank_access_allowed_r[i] <= 1'b1;
                  end
               end
            end
         end
      end
   end

   // handshake for each token; silence while frozen, for foreign address, bad config or endpoint reset
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         resp_r <= '0;
      end else begin
         resp_r <= '0;
         if (!soft_rst && !frozen && TOKEN.valid && TOKEN.ep < 3'd7 && addr_match()
             && !ep_hold[TOKEN.ep] && cfg_ok[TOKEN.ep]) begin
            resp_r.valid <= 1'b1;
            resp_r.toggle <= ep_tog_r[TOKEN.ep];
            resp_r.code <= ep_stall_r[TOKEN.ep] ? usbdc_pkg::HS_STALL : usbdc_pkg::HS_ACK;
         end
      end
   end

   // pins and interrupt lines, all registered
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pu_dp_r <= 1'b0;
         pu_dm_r <= 1'b0;
         full_r <= 1'b1;
         rsm_r <= 1'b0;
         clken_r <= 1'b0;
         devirq_r <= 1'b0;
         epirq_r <= 1'b0;
      end else begin
         pu_dp_r <= attach && !ctrl_r[usbdc_pkg::CT_LOW_SPEED];
         pu_dm_r <= attach && ctrl_r[usbdc_pkg::CT_LOW_SPEED];
         full_r <= fs_r || !ctrl_r[usbdc_pkg::CT_LOW_SPEED];
         rsm_r <= lstate_r == usbdc_pkg::LN_RESUME;
         clken_r <= !frozen;
         devirq_r <= |(flag_r & inten_r);
         epirq_r <= |((ep_stalled_r & ep_stie_r) | (ep_rxout_r & ep_rxie_r));
      end
   end

   assign WB_ACK_O = ack_r;
   assign WB_DAT_O = rdat_r;
   assign RESPONSE = resp_r;
   assign PULLUP_DP = pu_dp_r;
   assign PULLUP_DM = pu_dm_r;
   assign RESUME_DRIVE = rsm_r;
   assign FULL_SPEED = full_r;
   assign VBUS_ON = ctrl_r[usbdc_pkg::CT_VBUS_REQ];
   assign MACRO_CLK_EN = clken_r;
   assign DEV_IRQ = devirq_r;
   assign EP_IRQ = epirq_r;
endmodule

// ### src/usbdc_pkg.sv
// Purpose: shared constants and carrier types of the usb device control core
// Assumes: 250 MHz core clock, 32-bit classic Wishbone register slave
// Notes: byte offsets are word aligned; times are kept in microseconds
package usbdc_pkg;
   localparam int CLK_MHZ = 250;
   localparam int SUSP_TIME_US = 3000;
   localparam int RWK_TIME_US = 5000;
   localparam int RSM_TIME_US = 2000;
   localparam int BCON_TIME_US = 300000;
   localparam int SUSP_CYC = SUSP_TIME_US * CLK_MHZ;
   localparam int RWK_CYC = RWK_TIME_US * CLK_MHZ;
   localparam int RSM_CYC = RSM_TIME_US * CLK_MHZ;
   localparam int BCON_CYC = BCON_TIME_US * CLK_MHZ;
   localparam int TMR_W = 27;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_FLAGS = 8'h04;
   localparam logic [7:0] OFS_INTEN = 8'h08;
   localparam logic [7:0] OFS_ADDR = 8'h0C;
   localparam logic [7:0] OFS_EPSEL = 8'h10;
   localparam logic [7:0] OFS_EPRST = 8'h14;
   localparam logic [7:0] OFS_EPCFG = 8'h18;
   localparam logic [7:0] OFS_EPINT = 8'h1C;

   // control register fields
   localparam int CT_MACRO_EN = 0;
   localparam int CT_FREEZE = 1;
   localparam int CT_DETACH = 2;
   localparam int CT_LOW_SPEED = 3;
   localparam int CT_RWAKE = 4;
   localparam int CT_HOST = 5;
   localparam int CT_VBUS_REQ = 6;
   localparam logic [6:0] CTRL_RST = 7'h06;

   // device flag fields (write one to clear)
   localparam int FL_SUSP = 0;
   localparam int FL_WAKE = 1;
   localparam int FL_RSM_SENT = 2;
   localparam int FL_EORSM = 3;
   localparam int FL_BUS_RST = 4;
   localparam int FL_BCON_ERR = 5;
   localparam int FL_VBUS_ERR = 6;
   localparam int FL_SRP = 7;
   localparam int NFLAGS = 8;

   // address register fields
   localparam int AD_ENABLE = 7;
   localparam logic [6:0] DEF_ADDR = 7'h00;

   // endpoint config fields
   localparam int EC_EN = 0;
   localparam int EC_MEMORY_ALLOCATE_BIT = 1;
   localparam int EC_BANKS = 2;
   localparam int EC_SIZE_LO = 4;
   localparam int EC_TOG_RST = 8;
   localparam int EC_STALL_CLR = 9;
   localparam int EC_STALL_SET = 10;
   localparam int EC_STALL_IE = 11;
   localparam int EC_RX_IE = 12;
   localparam int EC_STALL_RQ = 14;
   localparam int EC_CFG_OK = 15;
   localparam int EC_TOGGLE = 16;

   // endpoint flag fields
   localparam int EI_STALLED = 0;
   localparam int EI_RX_OUT = 1;
   localparam int EI_BANK_ACCESS_ALLOWED = 2;

   localparam int NEP = 7;
   localparam logic [8:0] EP0_MAX = 9'h040;
   localparam logic [8:0] EP1_MAX = 9'h100;
   localparam logic [8:0] EPN_MAX = 9'h040;

   typedef enum logic [1:0] {TK_OUT, TK_IN, TK_SETUP} usbdc_tkind_t;
   typedef enum logic [1:0] {HS_NONE, HS_ACK, HS_NAK, HS_STALL} usbdc_hs_t;
   typedef enum logic [1:0] {LN_ACTIVE, LN_SUSPEND, LN_RESUME} usbdc_lstate_t;

   typedef struct packed {
      logic valid;
      usbdc_tkind_t kind;
      logic [6:0] addr;
      logic [2:0] ep;
   } usbdc_tok_t;

   typedef struct packed {
      logic valid;
      usbdc_hs_t code;
      logic toggle;
   } usbdc_resp_t;
endpackage

// ### src/usbdc_sync.sv
// Purpose: two-stage synchroniser for pin levels
// Assumes: inputs are asynchronous to CLK
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module usbdc_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // levels
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= '0;
         dout <= '0;
      end else begin
         meta_r <= din;
         dout <= meta_r;
      end
   end
endmodule

// ### src/usbdc_timer.sv
// Purpose: run-while-held cycle counter with a one-cycle done pulse
// Assumes: limit is at least one
// Notes: restarts whenever run drops; fires once per run
`timescale 1ns/1ps
module usbdc_timer (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic run,
   input wire logic [usbdc_pkg::TMR_W-1:0] limit,
   output logic done
);
   logic [usbdc_pkg::TMR_W-1:0] cnt_r;
   logic fired_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
         fired_r <= 1'b0;
         done <= 1'b0;
      end else if (!run) begin
         cnt_r <= '0;
         fired_r <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (!fired_r) begin
            if (cnt_r == limit - 1'b1) begin
               done <= 1'b1;
               fired_r <= 1'b1;
            end
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end
endmodule
